// file: design/dsf_channel.sv
`timescale 1ns/1ns
// one channel: sinc3, sinc1 post stage and fast-settling sinc1 path
module dsf_channel
    import dsf_pkg::*;
(
    input wire logic core_clk,
    input wire logic srst,
    input wire logic restart,
    input wire logic mod_tick,
    input wire logic dec_tick,
    input wire logic conv_tick,
    input wire logic use_sinc3,
    input wire logic post_en,
    input wire logic [4:0] sinc3_shift,
    input wire logic [2:0] post_shift,
    input wire logic [4:0] fast_shift,
    input wire logic mod_bit,
    output logic [SAMPLE_W-1:0] sample
);
    logic signed [Q_W-1:0] integ1, integ2, integ3, dly1, dly2, dly3, fast_acc;
    logic signed [Q_W-1:0] next_integ1, next_integ2, next_integ3;
    logic signed [Q_W-1:0] next_dly1, next_dly2, next_dly3, next_fast_acc;
    logic signed [POST_W-1:0] post_acc, next_post_acc;
    logic [SAMPLE_W-1:0] next_sample;
    logic signed [Q_W-1:0] step, comb1, comb2, comb3, sinc3_q, fast_sum, fast_q;
    logic signed [POST_W-1:0] post_sum, post_q, pick;

    // filter arithmetic and next state
    always_comb begin
        step = mod_bit ? Q_ONE : Q_MINUS_ONE;
        comb1 = integ3 - dly1;
        comb2 = comb1 - dly2;
        comb3 = comb2 - dly3;
        sinc3_q = comb3 <<< sinc3_shift;
        post_sum = post_acc + POST_W'(sinc3_q);
        post_q = post_sum >>> post_shift;
        fast_sum = fast_acc + step;
        fast_q = fast_sum <<< fast_shift;
        if (!use_sinc3) begin
            pick = POST_W'(fast_q);
        end else if (post_en) begin
            pick = post_q;
        end else begin
            pick = POST_W'(sinc3_q);
        end
        next_integ1 = integ1;
        next_integ2 = integ2;
        next_integ3 = integ3;
        next_dly1 = dly1;
        next_dly2 = dly2;
        next_dly3 = dly3;
        next_fast_acc = fast_acc;
        next_post_acc = post_acc;
        next_sample = sample;
        if (restart) begin
            // settling starts over, no result is held back
            next_integ1 = '0;
            next_integ2 = '0;
            next_integ3 = '0;
            next_dly1 = '0;
            next_dly2 = '0;
            next_dly3 = '0;
            next_fast_acc = '0;
            next_post_acc = '0;
            next_sample = '0;
        end else if (mod_tick) begin
            next_integ1 = integ1 + step;
            next_integ2 = integ2 + integ1;
            next_integ3 = integ3 + integ2;
            next_fast_acc = conv_tick ? '0 : fast_sum;
            if (dec_tick) begin
                next_dly1 = integ3;
                next_dly2 = comb1;
                next_dly3 = comb2;
                next_post_acc = conv_tick ? '0 : post_sum;
            end
            if (conv_tick) begin
                next_sample = dsf_to_sample(pick);
            end
        end
    end

    // filter registers
    always_ff @(posedge core_clk) begin
        if (srst) begin
            integ1 <= '0;
            integ2 <= '0;
            integ3 <= '0;
            dly1 <= '0;
            dly2 <= '0;
            dly3 <= '0;
            fast_acc <= '0;
            post_acc <= '0;
            sample <= '0;
        end else begin
            integ1 <= next_integ1;
            integ2 <= next_integ2;
            integ3 <= next_integ3;
            dly1 <= next_dly1;
            dly2 <= next_dly2;
            dly3 <= next_dly3;
            fast_acc <= next_fast_acc;
            post_acc <= next_post_acc;
            sample <= next_sample;
        end
    end
endmodule

// file: design/dsf_filter_top.sv
`timescale 1ns/1ns
// decimation filter of all channels with its register slave
// Operation
// - modulator runs at half the controller clock
// - one-bit ones-density stream feeds each filter
// - average and decimate, one sample per ratio
// - three-bit field selects ratio 128 to 16384
// - data rate is modulator rate over ratio
// - nominal clocks 8.192, 4.096, 2.048 MHz per mode
// - sinc3 and fast sinc1 paths run in parallel
// - fast sinc1 path drives output after reset
// - after two conversions switch to sinc3, stay
// - ratios up to 1024 bypass the sinc1 stage
// - above 1024: sinc3 at 1024, sinc1 the rest
// - enable, mux, gain change or resync restart settling
// - settling time depends on ratio, table given
// - unsettled samples still produced and flagged ready
// - first ready fall after settling is valid
// - two-bit field selects the power level
// - sinc3 response is cubed moving average
module dsf_filter_top
    import dsf_pkg::*;
(
    input wire logic core_clk,
    input wire logic srst,
    input wire logic [NCH-1:0] mod_bits,
    input wire logic [NCH-1:0] cfg_change,
    input wire logic resync,
    input wire logic [7:0] avs_address,
    input wire logic avs_read,
    input wire logic avs_write,
    input wire logic [31:0] avs_writedata,
    input wire logic [3:0] avs_byteenable,
    output logic [31:0] avs_readdata,
    output logic avs_waitrequest,
    output dsf_result_t result,
    output logic sample_ready_n,
    output logic [1:0] power_level
);
    // timing group
    logic mod_tick, next_mod_tick;
    logic [CNT_W-1:0] ovr_cnt, next_ovr_cnt;
    dsf_path_t path, next_path;
    logic [15:0] conv_count, next_conv_count;
    logic conv_d, next_conv_d;
    // path that made the conversion just latched, path itself moves on at that tick
    logic conv_sinc3, next_conv_sinc3;
    // register group
    logic [RATIO_W-1:0] rate_ratio_sel, next_rate_ratio_sel;
    logic [1:0] next_power_level;
    logic [NCH-1:0] chan_en, next_chan_en;
    logic [31:0] next_readdata;
    logic next_waitrequest;
    // output group
    dsf_result_t next_result;
    logic next_sample_ready_n;
    logic [3:0] ready_cnt, next_ready_cnt;
    // decoded settings
    logic [4:0] ratio_log, sinc3_log, sinc3_shift, fast_shift;
    logic [2:0] post_shift;
    logic post_en;
    logic [CNT_W-1:0] conv_mask, sinc3_mask;
    logic dec_tick, conv_tick, use_sinc3;
    logic bus_wr, bus_rd, ctrl_wr, resync_wr, restart_all;
    logic [NCH-1:0] restart_ch;
    logic [NCH-1:0][SAMPLE_W-1:0] chan_sample;
    logic [31:0] status_word;

    // ratio decode and tick generation
    always_comb begin
        ratio_log = 5'(RATIO_LOG_BASE) + {2'b00, rate_ratio_sel};
        if (ratio_log > 5'(SINC3_LOG_MAX)) begin
            sinc3_log = 5'(SINC3_LOG_MAX);
        end else begin
            sinc3_log = ratio_log;
        end
        post_en = ratio_log > sinc3_log;
        post_shift = 3'(ratio_log - sinc3_log);
        sinc3_shift = 5'(Q_FS_LOG) - 5'(sinc3_log * 5'd3);
        fast_shift = 5'(Q_FS_LOG) - ratio_log;
        conv_mask = CNT_W'((32'd1 << ratio_log) - 32'd1);
        sinc3_mask = CNT_W'((32'd1 << sinc3_log) - 32'd1);
        dec_tick = mod_tick && ((ovr_cnt & sinc3_mask) == sinc3_mask);
        conv_tick = mod_tick && ((ovr_cnt & conv_mask) == conv_mask);
        use_sinc3 = (path == PATH_SINC3);
    end

    // bus strobes and restart sources
    always_comb begin
        bus_wr = avs_write && !avs_waitrequest;
        bus_rd = avs_read && !avs_waitrequest;
        ctrl_wr = bus_wr && (avs_address == ADDR_CTRL) && avs_byteenable[0];
        resync_wr = bus_wr && (avs_address == ADDR_RESYNC) && avs_byteenable[0] && avs_writedata[0];
        restart_all = resync || resync_wr || ctrl_wr;
        restart_ch = {NCH{restart_all}} | cfg_change | ~chan_en;
    end

    // timing next state
    always_comb begin
        next_mod_tick = !mod_tick;
        next_ovr_cnt = ovr_cnt;
        next_path = path;
        next_conv_count = conv_count;
        next_conv_d = conv_tick;
        next_conv_sinc3 = use_sinc3;
        if (restart_all) begin
            next_ovr_cnt = '0;
        end else if (mod_tick) begin
            next_ovr_cnt = ovr_cnt + CNT_W'(1);
        end
        if (conv_tick) begin
            next_conv_count = conv_count + 16'h0001;
            unique case (path)
                PATH_FAST_1: next_path = PATH_FAST_2;
                PATH_FAST_2: next_path = PATH_SINC3;
                PATH_SINC3: next_path = PATH_SINC3;
                default: next_path = PATH_FAST_1;
            endcase
        end
    end

    // timing registers
    always_ff @(posedge core_clk) begin
        if (srst) begin
            mod_tick <= 1'b0;
            ovr_cnt <= '0;
            path <= PATH_FAST_1;
            conv_count <= '0;
            conv_d <= 1'b0;
            conv_sinc3 <= 1'b0;
        end else begin
            mod_tick <= next_mod_tick;
            ovr_cnt <= next_ovr_cnt;
            path <= next_path;
            conv_count <= next_conv_count;
            conv_d <= next_conv_d;
            conv_sinc3 <= next_conv_sinc3;
        end
    end

    // one filter per channel, all on the same ticks
    genvar gi;
    generate
        for (gi = 0; gi < NCH; gi++) begin : g_chan
            dsf_channel u_chan (
                .core_clk(core_clk),
                .srst(srst),
                .restart(restart_ch[gi]),
                .mod_tick(mod_tick),
                .dec_tick(dec_tick),
                .conv_tick(conv_tick),
                .use_sinc3(use_sinc3),
                .post_en(post_en),
                .sinc3_shift(sinc3_shift),
                .post_shift(post_shift),
                .fast_shift(fast_shift),
                .mod_bit(mod_bits[gi]),
                .sample(chan_sample[gi])
            );
        end
    endgenerate

    // status word
    always_comb begin
        status_word = '0;
        status_word[2:0] = path;
        status_word[STATUS_EN_LSB +: NCH] = chan_en;
        status_word[STATUS_CONV_LSB +: 16] = conv_count;
    end

    // register writes, read mux and wait-state handshake
    always_comb begin
        next_rate_ratio_sel = rate_ratio_sel;
        next_power_level = power_level;
        next_chan_en = chan_en;
        next_readdata = avs_readdata;
        next_waitrequest = !((avs_read || avs_write) && avs_waitrequest);
        if (ctrl_wr) begin
            next_rate_ratio_sel = avs_writedata[CTRL_RATIO_LSB +: RATIO_W];
            next_power_level = avs_writedata[CTRL_PWR_LSB +: 2];
        end
        if (bus_wr && (avs_address == ADDR_CHAN_EN) && avs_byteenable[0]) begin
            next_chan_en = avs_writedata[NCH-1:0];
        end
        if (avs_read && avs_waitrequest) begin
            next_readdata = '0;
            if (avs_address == ADDR_CTRL) begin
                next_readdata[CTRL_RATIO_LSB +: RATIO_W] = rate_ratio_sel;
                next_readdata[CTRL_PWR_LSB +: 2] = power_level;
            end else if (avs_address == ADDR_CHAN_EN) begin
                next_readdata[NCH-1:0] = chan_en;
            end else if (avs_address == ADDR_STATUS) begin
                next_readdata = status_word;
            end else if (avs_address[7:5] == ADDR_SAMPLE_HI && avs_address[1:0] == 2'b00) begin
                next_readdata[SAMPLE_W-1:0] = result.data[avs_address[4:2]];
            end
        end
    end

    // register group flip-flops
    always_ff @(posedge core_clk) begin
        if (srst) begin
            rate_ratio_sel <= RATIO_RST;
            power_level <= PWR_RST;
            chan_en <= CHAN_EN_RST;
            avs_readdata <= '0;
            avs_waitrequest <= 1'b1;
        end else begin
            rate_ratio_sel <= next_rate_ratio_sel;
            power_level <= next_power_level;
            chan_en <= next_chan_en;
            avs_readdata <= next_readdata;
            avs_waitrequest <= next_waitrequest;
        end
    end

    // result capture and data-ready line, unsettled data included
    always_comb begin
        next_result = result;
        next_result.valid = conv_d;
        next_sample_ready_n = sample_ready_n;
        next_ready_cnt = ready_cnt;
        if (conv_d) begin
            next_result.data = chan_sample;
            next_result.from_sinc3 = conv_sinc3;
            next_sample_ready_n = 1'b0;
            next_ready_cnt = READY_LOW_CYC;
        end else if (!sample_ready_n) begin
            next_ready_cnt = ready_cnt - 4'h1;
            if (ready_cnt == 4'h1 || (bus_rd && avs_address == ADDR_SAMPLE_LAST)) begin
                next_sample_ready_n = 1'b1;
                next_ready_cnt = '0;
            end
        end
    end

    // output flip-flops
    always_ff @(posedge core_clk) begin
        if (srst) begin
            result <= '0;
            sample_ready_n <= 1'b1;
            ready_cnt <= '0;
        end else begin
            result <= next_result;
            sample_ready_n <= next_sample_ready_n;
            ready_cnt <= next_ready_cnt;
        end
    end
endmodule

// file: design/dsf_pkg.sv
// shared constants and types of the delta-sigma decimation filter
package dsf_pkg;
    // channel count and data widths
    localparam int NCH = 8;
    localparam int SAMPLE_W = 24;
    localparam int Q_W = 32;
    localparam int POST_W = 36;
    localparam int CNT_W = 14;
    localparam int RATIO_W = 3;
    // full scale of the internal accumulators is 2^30
    localparam int Q_FS_LOG = 30;
    // ratio code 0 is 2^7, the third-order stage stops at 2^10
    localparam int RATIO_LOG_BASE = 7;
    localparam int SINC3_LOG_MAX = 10;
    // modulator runs at the controller clock over this
    localparam int MOD_CLK_DIV = 2;
    localparam int CORE_CLK_KHZ = 100000;
    // nominal controller clocks per power level
    localparam int HIGH_RES_CLK_KHZ = 8192;
    localparam int LOW_POWER_CLK_KHZ = 4096;
    localparam int VERY_LOW_POWER_CLK_KHZ = 2048;
    localparam logic [1:0] HIGH_RES_SETTING = 2'h0;
    localparam logic [1:0] LOW_POWER_SETTING = 2'h1;
    localparam logic [1:0] VERY_LOW_POWER_SETTING = 2'h2;
    // settling in controller clock periods, indexed by ratio code
    localparam int SETTLE_CONTROLLER_CLOCK_IN [8] = '{856, 1112, 1624, 2648, 4696, 8792, 16984, 33368};
    // low time of the data-ready line
    localparam int READY_LOW_NS = 80;
    localparam int READY_LOW_CYC_I = READY_LOW_NS * CORE_CLK_KHZ / 1000000;
    localparam logic [3:0] READY_LOW_CYC = 4'(READY_LOW_CYC_I < 1 ? 1 : READY_LOW_CYC_I);
    // register byte offsets
    localparam logic [7:0] ADDR_CTRL = 8'h00;
    localparam logic [7:0] ADDR_CHAN_EN = 8'h04;
    localparam logic [7:0] ADDR_STATUS = 8'h08;
    localparam logic [7:0] ADDR_RESYNC = 8'h0c;
    localparam logic [2:0] ADDR_SAMPLE_HI = 3'h1;
    localparam logic [7:0] ADDR_SAMPLE_LAST = 8'h3c;
    // field positions
    localparam int CTRL_RATIO_LSB = 0;
    localparam int CTRL_PWR_LSB = 4;
    localparam int STATUS_EN_LSB = 8;
    localparam int STATUS_CONV_LSB = 16;
    // values after reset
    localparam logic [RATIO_W-1:0] RATIO_RST = 3'h0;
    localparam logic [1:0] PWR_RST = 2'h0;
    localparam logic [NCH-1:0] CHAN_EN_RST = 8'hff;
    // saturation bounds of a sample, at accumulator width
    localparam logic signed [POST_W-1:0] SAT_HI = 36'sh0007fffff;
    localparam logic signed [POST_W-1:0] SAT_LO = 36'shfff800000;
    localparam logic signed [Q_W-1:0] Q_ONE = 32'sh00000001;
    localparam logic signed [Q_W-1:0] Q_MINUS_ONE = 32'shffffffff;

    // output path after reset: two fast conversions, then sinc3
    typedef enum logic [2:0] {
        PATH_FAST_1 = 3'b001,
        PATH_FAST_2 = 3'b010,
        PATH_SINC3 = 3'b100
    } dsf_path_t;

    // one set of simultaneous samples
    typedef struct packed {
        logic valid;
        logic from_sinc3;
        logic [NCH-1:0][SAMPLE_W-1:0] data;
    } dsf_result_t;

    // scale a 2^30 full-scale value to a saturated sample
    function automatic logic [SAMPLE_W-1:0] dsf_to_sample(input logic signed [POST_W-1:0] q);
        logic signed [POST_W-1:0] s;
        s = q >>> (Q_FS_LOG - SAMPLE_W + 1);
        if (s > SAT_HI) begin
            return SAT_HI[SAMPLE_W-1:0];
        end else if (s < SAT_LO) begin
            return SAT_LO[SAMPLE_W-1:0];
        end
        return s[SAMPLE_W-1:0];
    endfunction
endpackage

// file: tb/dsf_filter_chk.sv
// assertion checker on the decimation filter ports
`timescale 1ns/1ns
module dsf_filter_chk
    import dsf_pkg::*;
(
    input wire logic core_clk,
    input wire logic srst,
    input wire logic avs_read,
    input wire logic avs_write,
    input wire logic avs_waitrequest,
    input wire dsf_result_t result,
    input wire logic sample_ready_n
);
    default clocking @(posedge core_clk); endclocking
    default disable iff (srst);
    logic [1:0] conv_seen;
    logic [1:0] next_conv_seen;
    // count the first results after reset, saturating
    always_comb begin
        next_conv_seen = conv_seen;
        if (result.valid && conv_seen != 2'h3) begin
            next_conv_seen = conv_seen + 2'h1;
        end
    end
    // register the result count
    always_ff @(posedge core_clk) begin
        if (srst) begin
            conv_seen <= 2'h0;
        end else begin
            conv_seen <= next_conv_seen;
        end
    end
    AST_BUS_ANSWER: assert property ((avs_read || avs_write) && avs_waitrequest |=> !avs_waitrequest)
        else $error("bus request not answered in one cycle");
    AST_BUS_ONE: assert property (!avs_waitrequest |=> avs_waitrequest)
        else $error("bus answer longer than one cycle");
    AST_BUS_CAUSE: assert property (!avs_waitrequest |-> $past(avs_read || avs_write))
        else $error("bus answer without request");
    AST_VALID_PULSE: assert property (result.valid |=> !result.valid)
        else $error("result valid longer than one cycle");
    AST_READY_WITH_VALID: assert property (result.valid |-> !sample_ready_n)
        else $error("new result without ready low");
    AST_READY_CAUSE: assert property ($fell(sample_ready_n) |-> result.valid)
        else $error("ready fell without a result");
    AST_READY_BOUND: assert property ($fell(sample_ready_n) |-> ##[1:8] sample_ready_n)
        else $error("ready low too long");
    AST_FAST_FIRST: assert property (result.valid && conv_seen < 2'h2 |-> !result.from_sinc3)
        else $error("early result not from fast path");
    AST_SINC3_AFTER: assert property (result.valid && conv_seen >= 2'h2 |-> result.from_sinc3)
        else $error("third result not from sinc3 path");
    AST_SINC3_HOLD: assert property (result.from_sinc3 |=> result.from_sinc3)
        else $error("left sinc3 path without reset");
    AST_DATA_HOLD: assert property (!result.valid |-> $stable(result.data))
        else $error("sample data changed without a result");
    cover property (result.valid && result.from_sinc3);
    cover property ($fell(sample_ready_n));
    cover property (avs_write && !avs_waitrequest);
endmodule
bind dsf_filter_top dsf_filter_chk u_chk(.core_clk(core_clk), .srst(srst), .avs_read(avs_read),
    .avs_write(avs_write), .avs_waitrequest(avs_waitrequest), .result(result), .sample_ready_n(sample_ready_n));

// file: tb/dsf_host_model.sv
// host model tracking filter settling on the data-ready line
`timescale 1ns/1ns
module dsf_host_model
    import dsf_pkg::*;
(
    input wire logic core_clk,
    input wire logic srst,
    input wire logic restart,
    input wire logic [2:0] rate_code,
    input wire logic sample_ready_n,
    output logic settled
);
    int elapsed;
    logic ready_d;
    // count settling clocks, trust first ready fall after them
    always @(posedge core_clk) begin
        ready_d <= sample_ready_n;
        if (srst || restart) begin
            elapsed <= 0;
            settled <= 1'b0;
        end else begin
            elapsed <= elapsed + 1;
            if (ready_d && !sample_ready_n && elapsed >= SETTLE_CONTROLLER_CLOCK_IN[rate_code]) begin
                settled <= 1'b1;
            end
        end
    end
endmodule

// file: tb/test_delta_sigma_decimation_filter.sv
// self-checking bench of the decimation filter
`timescale 1ns/1ns
module test_delta_sigma_decimation_filter;
    import dsf_pkg::*;
    logic core_clk = 1'b0;
    logic srst = 1'b1;
    logic [NCH-1:0] mod_bits = '1;
    logic [NCH-1:0] cfg_change = '0;
    logic resync = 1'b0;
    logic [7:0] avs_address = 8'h00;
    logic avs_read = 1'b0;
    logic avs_write = 1'b0;
    logic [31:0] avs_writedata = 32'h0;
    logic [31:0] avs_readdata;
    logic avs_waitrequest;
    dsf_result_t result;
    logic sample_ready_n;
    logic [1:0] power_level;
    logic host_restart = 1'b0;
    logic [2:0] host_code = 3'h0;
    logic settled;
    int err_total = 0;
    int cmp_count = 0;
    int period;
    logic [31:0] rd;
    logic [2:0] row_code [5] = '{3'h0, 3'h1, 3'h2, 3'h3, 3'h4};
    logic [1:0] row_pwr [5] = '{2'h0, 2'h1, 2'h2, 2'h0, 2'h1};
    int row_period [5] = '{256, 512, 1024, 2048, 4096};

    // clock
    always #5 core_clk = ~core_clk;

    dsf_filter_top u_dut(.core_clk(core_clk), .srst(srst), .mod_bits(mod_bits), .cfg_change(cfg_change),
        .resync(resync), .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
        .avs_writedata(avs_writedata), .avs_byteenable(4'h1), .avs_readdata(avs_readdata),
        .avs_waitrequest(avs_waitrequest), .result(result), .sample_ready_n(sample_ready_n),
        .power_level(power_level));
    dsf_host_model u_host(.core_clk(core_clk), .srst(srst), .restart(host_restart), .rate_code(host_code),
        .sample_ready_n(sample_ready_n), .settled(settled));

    task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
        cmp_count++;
        if (got !== exp) begin
            err_total++;
            $display("BAD %s expected %h seen %h", what, exp, got);
        end
    endtask

    // one bus access; writes of control or resync restart the host tracking
    task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] d);
        int n;
        n = 0;
        @(posedge core_clk);
        avs_address <= a;
        avs_writedata <= d;
        avs_write <= wr;
        avs_read <= !wr;
        do begin
            @(posedge core_clk);
            n++;
        end while (avs_waitrequest !== 1'b0 && n < 50);
        rd = avs_readdata;
        avs_write <= 1'b0;
        avs_read <= 1'b0;
        host_restart <= wr && (a == ADDR_CTRL || a == ADDR_RESYNC);
        @(posedge core_clk);
        host_restart <= 1'b0;
        if (n >= 50) err_total++;
    endtask

    task automatic wait_valid(output int n);
        n = 0;
        do begin
            @(posedge core_clk);
            n++;
        end while (result.valid !== 1'b1 && n < 20000);
        if (n >= 20000) err_total++;
    endtask

    task automatic wait_settled;
        int n;
        n = 0;
        do begin
            @(posedge core_clk);
            n++;
        end while (settled !== 1'b1 && n < 5000);
        if (n >= 5000) err_total++;
    endtask

    task automatic chk_all(input logic [23:0] exp);
        for (int c = 0; c < NCH; c++) chk("sample", {8'h0, exp}, {8'h0, result.data[c]});
    endtask

    task final_report;
        $display("comparisons %0d mismatches %0d", cmp_count, err_total);
        if (err_total == 0 && cmp_count > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask

    // watchdog against a hang
    initial begin
        #1000000;
        err_total++;
        final_report();
    end

    // main sequence
    initial begin
        repeat (8) @(posedge core_clk);
        chk("ready_n in reset", 32'h1, {31'h0, sample_ready_n});
        chk("waitrequest in reset", 32'h1, {31'h0, avs_waitrequest});
        chk("power in reset", 32'h0, {30'h0, power_level});
        srst <= 1'b0;
        // first three results after reset: two from the fast path, then one from sinc3
        for (int k = 0; k < 3; k++) begin
            wait_valid(period);
            chk("from_sinc3", {31'h0, k == 2}, {31'h0, result.from_sinc3});
        end
        wait_settled();
        chk_all(24'h7fffff);
        mod_bits <= '0;
        bus(1'b1, ADDR_CTRL, 32'h0);
        wait_settled();
        chk_all(24'h800000);
        wait_valid(period);
        bus(1'b0, ADDR_SAMPLE_LAST, 32'h0);
        chk("last sample", 32'h00800000, rd);
        repeat (2) @(posedge core_clk);
        chk("ready_n after read", 32'h1, {31'h0, sample_ready_n});
        bus(1'b0, 8'h80, 32'h0);
        chk("unmapped", 32'h0, rd);
        bus(1'b1, ADDR_RESYNC, 32'h1);
        cfg_change <= 8'h01;
        resync <= 1'b1;
        @(posedge core_clk);
        cfg_change <= 8'h00;
        resync <= 1'b0;
        wait_valid(period);
        chk("sinc3 after resync", 32'h1, {31'h0, result.from_sinc3});
        bus(1'b0, ADDR_STATUS, 32'h0);
        chk("path", 32'h4, {29'h0, rd[2:0]});
        // disabled channel is held at zero
        bus(1'b1, ADDR_CHAN_EN, 32'h000000fe);
        wait_valid(period);
        chk("disabled channel", 32'h0, {8'h0, result.data[0]});
        bus(1'b0, ADDR_CHAN_EN, 32'h0);
        chk("chan_en", 32'hfe, rd);
        bus(1'b1, ADDR_CHAN_EN, 32'h000000ff);
        for (int i = 0; i < 5; i++) begin
            host_code <= row_code[i];
            bus(1'b1, ADDR_CTRL, {26'h0, row_pwr[i], 1'b0, row_code[i]});
            @(posedge core_clk);
            chk("power level", {30'h0, row_pwr[i]}, {30'h0, power_level});
            wait_valid(period);
            wait_valid(period);
            chk("period", row_period[i], period);
        end
        // second reset in mid-run goes back to the fast path
        srst <= 1'b1;
        repeat (2) @(posedge core_clk);
        srst <= 1'b0;
        @(posedge core_clk);
        chk("power after reset", 32'h0, {30'h0, power_level});
        for (int k = 0; k < 3; k++) begin
            wait_valid(period);
            chk("from_sinc3 again", {31'h0, k == 2}, {31'h0, result.from_sinc3});
        end
        wait_valid(period);
        chk("period after reset", 256, period);
        final_report();
    end
endmodule
